// ### tiocg_top.sv
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

// ****************************************************************
// timer i/o configuration guard
// ****************************************************************

module tiocg_top (
    input  wire logic                           clk,
    input  wire logic                           resetn,
    input  wire tiocg_pkg::tiocg_bus_req_s      bus_req,
    input  wire logic [tiocg_pkg::N_OUT-1:0]    out_toggle,
    input  wire logic [tiocg_pkg::N_CAP-1:0]    capture_in,
    input  wire logic                           event_in,
    input  wire logic                           trigger_in,
    output logic      [tiocg_pkg::DATA_W-1:0]   rdata,
    output logic      [tiocg_pkg::N_OUT-1:0]    timer_output_pin,
    output logic      [tiocg_pkg::N_CAP-1:0]    capture_strobe,
    output logic                                event_count_pulse,
    output logic                                trigger_pulse
);
    import tiocg_pkg::*;

    // ************************************************************
    // state record
    // ************************************************************

    typedef struct packed {
        logic              timer_run_enable;
        logic              external_event_input_enable;
        tiocg_mode_e       operating_mode_field;
        logic [N_OUT-1:0]  output_pin_enable;
        logic [N_OUT-1:0]  output_level_select;
        logic [7:0]        capture_edge_select;
        logic [1:0]        event_edge_select;   // hi, lo
        logic [1:0]        trigger_edge_select; // hi, lo
        logic              guard_err;
        logic [N_OUT-1:0]  out_phase;
        logic [N_CAP-1:0]  cap_s1;
        logic [N_CAP-1:0]  cap_s2;
        logic [N_CAP-1:0]  cap_prev;
        logic              evt_s1;
        logic              evt_s2;
        logic              evt_prev;
        logic              trg_s1;
        logic              trg_s2;
        logic              trg_prev;
        logic [DATA_W-1:0] rdata;
        logic [N_OUT-1:0]  pin;
        logic [N_CAP-1:0]  cap_strobe;
        logic              evt_pulse;
        logic              trg_pulse;
    } tiocg_state_s;

    tiocg_state_s s_q;
    tiocg_state_s s_d;

    // ************************************************************
    // helpers
    // ************************************************************

    // edge detector against a selected polarity
    function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                      input logic cur);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = prev & ~cur;
        case (sel)
            EDGE_RISING:  edge_hit = rise;
            EDGE_FALLING: edge_hit = fall;
            EDGE_BOTH:    edge_hit = rise | fall;
            default:      edge_hit = 1'b0;
        endcase
    endfunction

    // decoded write to one register
    function automatic logic wr_at(input tiocg_bus_req_s r, input logic [ADDR_W-1:0] ofs);
        wr_at = r.wr && (r.addr == ofs);
    endfunction

    logic       cap_mode_ok;
    logic       evt_sel_ok;
    logic       trg_sel_ok;
    logic [7:0] wr_byte;

    assign cap_mode_ok = (s_q.operating_mode_field == MODE_FREE_RUN) ||
                         (s_q.operating_mode_field == MODE_PULSE_WIDTH);
    assign evt_sel_ok = s_q.external_event_input_enable ||
                        (s_q.operating_mode_field == MODE_EVENT_COUNT);
    assign trg_sel_ok = (s_q.operating_mode_field == MODE_EXT_TRIGGER) ||
                        (s_q.operating_mode_field == MODE_ONE_SHOT);
    assign wr_byte = bus_req.wdata[7:0];

    // ************************************************************
    // next state
    // ************************************************************

    always_comb begin
        logic changed;
        logic [1:0] cap_sel;
        changed = 1'b0;
        cap_sel = 2'b00;
        s_d = s_q;

        // pin synchronisers, first stage read only by second
        s_d.cap_s1   = capture_in;
        s_d.cap_s2   = s_q.cap_s1;
        s_d.cap_prev = s_q.cap_s2;
        s_d.evt_s1   = event_in;
        s_d.evt_s2   = s_q.evt_s1;
        s_d.evt_prev = s_q.evt_s2;
        s_d.trg_s1   = trigger_in;
        s_d.trg_s2   = s_q.trg_s1;
        s_d.trg_prev = s_q.trg_s2;

        // register writes
        if (wr_at(bus_req, OFS_CTL0)) begin
            s_d.timer_run_enable = wr_byte[CTL0_RUN_BIT];
        end
        if (wr_at(bus_req, OFS_CTL1)) begin
            // mode or enable changed while running
            changed = (wr_byte[CTL1_MODE_LSB +: 3] != s_q.operating_mode_field) ||
                      (wr_byte[CTL1_EEE_BIT] != s_q.external_event_input_enable);
            s_d.operating_mode_field        = tiocg_mode_e'(wr_byte[CTL1_MODE_LSB +: 3]);
            s_d.external_event_input_enable = wr_byte[CTL1_EEE_BIT];
        end
        if (wr_at(bus_req, OFS_OUTC)) begin
            changed = (wr_byte[OUTC_OE_LSB +: N_OUT] != s_q.output_pin_enable) ||
                      (wr_byte[OUTC_OL_LSB +: N_OUT] != s_q.output_level_select);
            s_d.output_pin_enable   = wr_byte[OUTC_OE_LSB +: N_OUT];
            s_d.output_level_select = wr_byte[OUTC_OL_LSB +: N_OUT];
        end
        if (wr_at(bus_req, OFS_CAPE)) begin
            changed = (wr_byte != s_q.capture_edge_select);
            s_d.capture_edge_select = wr_byte;
        end
        if (wr_at(bus_req, OFS_EVTR)) begin
            // event or trigger edges changed while running
            changed = (wr_byte[EVTR_EVT_LSB +: 2] != s_q.event_edge_select) ||
                      (wr_byte[EVTR_TRG_LSB +: 2] != s_q.trigger_edge_select);
            s_d.event_edge_select   = wr_byte[EVTR_EVT_LSB +: 2];
            s_d.trigger_edge_select = wr_byte[EVTR_TRG_LSB +: 2];
        end

        // sticky flag, set only on a real change while running
        if (wr_at(bus_req, OFS_STAT) && wr_byte[STAT_ERR_BIT]) begin
            s_d.guard_err = 1'b0;
        end
        if (changed && s_q.timer_run_enable) begin
            s_d.guard_err = 1'b1;
        end

        // output phase toggles only while running and enabled
        if (!s_q.timer_run_enable) begin
            s_d.out_phase = '0;
        end else begin
            s_d.out_phase = s_q.out_phase ^ (out_toggle & s_q.output_pin_enable);
        end

        // pin tracks level select, idle or not
        s_d.pin = s_d.output_level_select ^ (s_d.out_phase & s_d.output_pin_enable);

        // captures honour edges only in capture modes
        for (int i = 0; i < N_CAP; i++) begin
            cap_sel = s_q.capture_edge_select[2*i +: 2];
            s_d.cap_strobe[i] = s_q.timer_run_enable && cap_mode_ok &&
                                edge_hit(cap_sel, s_q.cap_prev[i], s_q.cap_s2[i]);
        end

        s_d.evt_pulse = s_q.timer_run_enable && evt_sel_ok &&
                        edge_hit(s_q.event_edge_select, s_q.evt_prev, s_q.evt_s2);
        s_d.trg_pulse = s_q.timer_run_enable && trg_sel_ok &&
                        edge_hit(s_q.trigger_edge_select, s_q.trg_prev, s_q.trg_s2);

        // read data stands one cycle after the strobe only
        s_d.rdata = RDATA_RST;
        if (bus_req.rd) begin
            case (bus_req.addr)
                OFS_CTL0: s_d.rdata[CTL0_RUN_BIT] = s_q.timer_run_enable;
                OFS_CTL1: begin
                    s_d.rdata[CTL1_MODE_LSB +: 3] = s_q.operating_mode_field;
                    s_d.rdata[CTL1_EEE_BIT]       = s_q.external_event_input_enable;
                end
                OFS_OUTC: begin
                    s_d.rdata[OUTC_OE_LSB +: N_OUT] = s_q.output_pin_enable;
                    s_d.rdata[OUTC_OL_LSB +: N_OUT] = s_q.output_level_select;
                end
                OFS_CAPE: s_d.rdata[CAPE_LSB +: 8] = s_q.capture_edge_select;
                OFS_EVTR: begin
                    s_d.rdata[EVTR_EVT_LSB +: 2] = s_q.event_edge_select;
                    s_d.rdata[EVTR_TRG_LSB +: 2] = s_q.trigger_edge_select;
                end
                OFS_STAT: begin
                    s_d.rdata[STAT_ERR_BIT] = s_q.guard_err;
                    s_d.rdata[STAT_RUN_BIT] = s_q.timer_run_enable;
                end
                default: s_d.rdata = RDATA_RST; // unmapped reads zero
            endcase
        end
    end

    // ************************************************************
    // state register
    // ************************************************************

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.operating_mode_field <= tiocg_mode_e'(MODE_RST);
            s_q.capture_edge_select  <= CAPE_RST;
            s_q.event_edge_select    <= SEL_RST;
            s_q.trigger_edge_select  <= SEL_RST;
            s_q.rdata                <= RDATA_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops
    assign rdata             = s_q.rdata;
    assign timer_output_pin  = s_q.pin;
    assign capture_strobe    = s_q.cap_strobe;
    assign event_count_pulse = s_q.evt_pulse;
    assign trigger_pulse     = s_q.trg_pulse;

    // ************************************************************
    // checks
    // ************************************************************

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_pin_idle_level: assert property (
        (wr_at(bus_req, OFS_OUTC) && !s_q.timer_run_enable)
        |=> timer_output_pin == $past(wr_byte[OUTC_OL_LSB +: N_OUT]))
        else $error("pin does not follow level select while stopped");

    a_capture_mode_gate: assert property (
        (capture_strobe != '0) |-> $past(cap_mode_ok) && $past(s_q.timer_run_enable))
        else $error("capture outside capture modes");

    a_event_edge_gate: assert property (
        event_count_pulse |-> $past(evt_sel_ok))
        else $error("event edge used while not valid");

    a_trigger_edge_gate: assert property (
        trigger_pulse |-> $past(trg_sel_ok))
        else $error("trigger edge used outside trigger modes");

    // same value while running leaves flag clear
    a_same_value_quiet: assert property (
        (wr_at(bus_req, OFS_CAPE) && s_q.timer_run_enable && !s_q.guard_err &&
         wr_byte == s_q.capture_edge_select)
        |=> !s_q.guard_err)
        else $error("same-value write flagged");

    a_change_flags_err: assert property (
        (wr_at(bus_req, OFS_EVTR) && s_q.timer_run_enable &&
         (wr_byte[EVTR_EVT_LSB +: 2] != s_q.event_edge_select ||
          wr_byte[EVTR_TRG_LSB +: 2] != s_q.trigger_edge_select))
        |=> s_q.guard_err ##1
            (s_q.guard_err || $past(wr_at(bus_req, OFS_STAT) && wr_byte[STAT_ERR_BIT])))
        else $error("guarded change while running not flagged");

    a_err_sticky: assert property (
        (s_q.guard_err && !(wr_at(bus_req, OFS_STAT) && wr_byte[STAT_ERR_BIT]))
        |=> s_q.guard_err)
        else $error("guard flag dropped without clear");

    // read data only after a read strobe
    a_read_window: assert property (
        (!$past(bus_req.rd) |-> rdata == '0) and
        ((bus_req.rd && bus_req.addr == OFS_STAT)
         |=> rdata[STAT_ERR_BIT] == $past(s_q.guard_err)))
        else $error("read data outside its cycle");

endmodule // tiocg_top

// ### tiocg_pkg.sv
// ****************************************************************
// timer i/o configuration guard: shared constants and types
// ****************************************************************
package tiocg_pkg;

    // bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTL0 = 8'h00; // timer_control_0
    localparam logic [ADDR_W-1:0] OFS_CTL1 = 8'h04; // timer_control_1
    localparam logic [ADDR_W-1:0] OFS_OUTC = 8'h08; // output_control_reg
    localparam logic [ADDR_W-1:0] OFS_CAPE = 8'h0c; // capture_edge_reg
    localparam logic [ADDR_W-1:0] OFS_EVTR = 8'h10; // event_trigger_edge_reg
    localparam logic [ADDR_W-1:0] OFS_STAT = 8'h14; // guard status

    // channel counts
    localparam int N_OUT = 2;
    localparam int N_CAP = 4;

    // field positions
    localparam int CTL0_RUN_BIT = 0;
    localparam int CTL1_MODE_LSB = 0;
    localparam int CTL1_EEE_BIT = 5;
    localparam int OUTC_OE_LSB = 0;
    localparam int OUTC_OL_LSB = 2;
    localparam int CAPE_LSB = 0;
    localparam int EVTR_TRG_LSB = 0;
    localparam int EVTR_EVT_LSB = 2;
    localparam int STAT_ERR_BIT = 0;
    localparam int STAT_RUN_BIT = 1;

    // reset values
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [1:0] SEL_RST = 2'h0;
    localparam logic [7:0] CAPE_RST = 8'h00;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

    // operating modes
    typedef enum logic [2:0] {
        MODE_INTERVAL    = 3'b000,
        MODE_EVENT_COUNT = 3'b001,
        MODE_EXT_TRIGGER = 3'b010,
        MODE_ONE_SHOT    = 3'b011,
        MODE_PWM         = 3'b100,
        MODE_FREE_RUN    = 3'b101,
        MODE_PULSE_WIDTH = 3'b110,
        MODE_RESERVED    = 3'b111
    } tiocg_mode_e;

    // edge selects
    typedef enum logic [1:0] {
        EDGE_NONE    = 2'b00,
        EDGE_RISING  = 2'b01,
        EDGE_FALLING = 2'b10,
        EDGE_BOTH    = 2'b11
    } tiocg_edge_e;

    // register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } tiocg_bus_req_s;

endpackage

// ### tiocg_bench.sv
`timescale 1ns/1ps

// ****************************************************************
// self-checking bench for the timer i/o configuration guard
// ****************************************************************
module tiocg_bench;
    import tiocg_pkg::*;

    logic                 clk;
    logic                 resetn;
    tiocg_bus_req_s       bus_req;
    logic [N_OUT-1:0]     out_toggle;
    logic [N_CAP-1:0]     capture_in;
    logic                 event_in;
    logic                 trigger_in;
    logic [DATA_W-1:0]    rdata;
    logic [N_OUT-1:0]     timer_output_pin;
    logic [N_CAP-1:0]     capture_strobe;
    logic                 event_count_pulse;
    logic                 trigger_pulse;
    int                   num_errors;
    int                   total_checks;
    int                   cycles;
    int                   nc, ne, nt;

    tiocg_top uut (
        .clk               (clk),
        .resetn            (resetn),
        .bus_req           (bus_req),
        .out_toggle        (out_toggle),
        .capture_in        (capture_in),
        .event_in          (event_in),
        .trigger_in        (trigger_in),
        .rdata             (rdata),
        .timer_output_pin  (timer_output_pin),
        .capture_strobe    (capture_strobe),
        .event_count_pulse (event_count_pulse),
        .trigger_pulse     (trigger_pulse)
    );

    // clock at 40 mhz
    always #12.5 clk = ~clk;

    // hang guard: every test ends well inside this many cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    // compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_req.addr  <= a;
        bus_req.wdata <= d;
        bus_req.wr    <= 1'b1;
        @(posedge clk);
        bus_req.wr    <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the following cycle only
    task automatic rd_check(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        bus_req.addr <= a;
        bus_req.rd   <= 1'b1;
        @(posedge clk);
        bus_req.rd   <= 1'b0;
        @(negedge clk);
        check(what, rdata, exp);
    endtask

    // let registered outputs land
    task automatic settle();
        repeat (2) @(negedge clk);
    endtask

    // stop, load mode and edge selects, start again
    task automatic cfg(input logic [2:0] m, input logic eee, input logic [7:0] cape,
                       input logic [7:0] evtr);
        wr(OFS_CTL0, 32'h0000_0000);
        wr(OFS_CTL1, {26'h0, eee, 2'h0, m});
        wr(OFS_CAPE, {24'h0, cape});
        wr(OFS_EVTR, {24'h0, evtr});
        wr(OFS_CTL0, 32'h0000_0001);
    endtask

    // one rise and one fall on all pins, counting the pulses that come out
    task automatic edges();
        nc = 0;
        ne = 0;
        nt = 0;
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            capture_in <= (p == 0) ? 4'hf : 4'h0;
            event_in   <= (p == 0);
            trigger_in <= (p == 0);
            repeat (8) begin
                @(negedge clk);
                nc += $countones(capture_strobe);
                ne += event_count_pulse;
                nt += trigger_pulse;
            end
        end
    endtask

    // reset values and unmapped places read zero
    task automatic t_reset();
        wr(8'h18, 32'h0000_00ff);
        for (int a = 0; a < 32; a += 4) begin
            rd_check("reset read", a[7:0], 32'h0000_0000);
        end
        check("pins after reset", timer_output_pin, 32'h0);
        $display("test reset done");
    endtask

    // pin level and phase behaviour
    task automatic t_output();
        wr(OFS_OUTC, 32'h0000_000c);
        settle();
        check("pin level 11", timer_output_pin, 32'h3);
        wr(OFS_OUTC, 32'h0000_0004);
        settle();
        check("pin level 01", timer_output_pin, 32'h1);
        rd_check("outc readback", OFS_OUTC, 32'h0000_0004);
        wr(OFS_OUTC, 32'h0000_0001);
        wr(OFS_CTL0, 32'h0000_0001);
        @(posedge clk);
        out_toggle <= 2'b11;
        @(posedge clk);
        out_toggle <= 2'b00;
        settle();
        check("pin toggled", timer_output_pin, 32'h1);
        wr(OFS_CTL0, 32'h0000_0000);
        settle();
        check("pin after stop", timer_output_pin, 32'h0);
        $display("test output done");
    endtask

    // mode gating of capture, event and trigger edges
    task automatic t_modes();
        for (int m = 0; m < 8; m++) begin
            for (int e = 0; e < 2; e++) begin
                cfg(m[2:0], e[0], 8'h55, 8'h05);
                edges();
                check("capture count", nc, (m == 5 || m == 6) ? 4 : 0);
                check("event count", ne, (e == 1 || m == 1) ? 1 : 0);
                check("trigger count", nt, (m == 2 || m == 3) ? 1 : 0);
            end
        end
        // capture mode with event enabled, then stopped: nothing may come out
        cfg(MODE_FREE_RUN, 1'b1, 8'h55, 8'h05);
        wr(OFS_CTL0, 32'h0000_0000);
        edges();
        check("no capture stopped", nc, 0);
        check("no event stopped", ne, 0);
        $display("test modes done");
    endtask

    // every edge code in a capture mode and in a trigger mode
    task automatic t_codes();
        int n;
        for (int c = 0; c < 4; c++) begin
            n = c[0] + c[1];
            cfg(MODE_FREE_RUN, 1'b1, {4{c[1:0]}}, {4'h0, c[1:0], c[1:0]});
            edges();
            check("capture code", nc, 4 * n);
            check("event code", ne, n);
            cfg(MODE_ONE_SHOT, 1'b0, {4{c[1:0]}}, {4'h0, c[1:0], c[1:0]});
            edges();
            check("trigger code", nt, n);
            check("capture off", nc, 0);
        end
        $display("test codes done");
    endtask

    // write guard while running
    task automatic t_guard();
        logic [7:0] a;
        cfg(MODE_FREE_RUN, 1'b0, 8'h55, 8'h05);
        wr(OFS_CTL1, 32'h0000_0005);
        wr(OFS_CAPE, 32'h0000_0055);
        wr(OFS_EVTR, 32'h0000_0005);
        wr(OFS_OUTC, 32'h0000_0001);
        rd_check("status same value", OFS_STAT, 32'h0000_0002);
        edges();
        check("capture undisturbed", nc, 4);
        // changing writes flagged, cleared by one
        for (int i = 0; i < 4; i++) begin
            a = OFS_CTL1 + 8'(4 * i);
            wr(a, (i == 1) ? 32'h0000_0005 : 32'h0000_0006);
            rd_check("status changed", OFS_STAT, 32'h0000_0003);
            wr(OFS_STAT, 32'h0000_0001);
            rd_check("status cleared", OFS_STAT, 32'h0000_0002);
        end
        wr(OFS_CTL0, 32'h0000_0000);
        wr(OFS_OUTC, 32'h0000_0008);
        settle();
        rd_check("status after rewrite", OFS_STAT, 32'h0000_0000);
        check("pin after rewrite", timer_output_pin, 32'h2);
        $display("test guard done");
    endtask

    // report and stop
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        clk          = 1'b0;
        resetn       = 1'b0;
        bus_req      = '0;
        out_toggle   = '0;
        capture_in   = '0;
        event_in     = 1'b0;
        trigger_in   = 1'b0;
        num_errors   = 0;
        total_checks = 0;
        cycles       = 0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_output();
        t_modes();
        t_codes();
        t_guard();
        give_verdict();
    end
endmodule // tiocg_bench
